// ==== verilog/clk_gen_pkg.sv ====
// Constants, register map and carrier types of the clock generation block.
// Assumes one 100 MHz register clock and a 32-bit AXI4-Lite register bus.
package clk_gen_pkg;

  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OSC_CTRL_OFS = 12'h000;
  localparam logic [11:0] MAIN_DIV_OFS = 12'h004;
  localparam logic [11:0] AUX_DIV_OFS  = 12'h008;
  localparam logic [11:0] AUX_CTRL_OFS = 12'h00c;

  // Oscillator control fields
  localparam int NEW_SRC_LSB   = 0;
  localparam int CUR_SRC_LSB   = 4;
  localparam int SRC_W         = 3;
  localparam int SW_REQ_BIT    = 8;
  localparam int MAIN_LOCK_BIT = 9;
  localparam int AUX_LOCK_BIT  = 10;
  localparam int SW_BUSY_BIT   = 11;

  // Divider register fields, same layout for both multipliers
  localparam int PRE_LSB   = 0;
  localparam int PRE_W     = 4;
  localparam int FB_LSB    = 8;
  localparam int FB_W      = 8;
  localparam int POST1_LSB = 16;
  localparam int POST2_LSB = 20;
  localparam int POST_W    = 3;

  // Auxiliary control fields
  localparam int AUX_EN_BIT  = 0;
  localparam int AUX_RUN_BIT = 1;
  localparam int AUX_REQ_BIT = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SRC_FAST_RC      = 3'h0,
    SRC_FAST_RC_PLL  = 3'h1,
    SRC_PRIMARY      = 3'h2,
    SRC_PRIMARY_PLL  = 3'h3,
    SRC_LOW_POWER_RC = 3'h5,
    SRC_BACKUP_RC    = 3'h6
  } src_t;

  typedef struct packed {
    logic [2:0] post2;
    logic [2:0] post1;
    logic [7:0] feedback;
    logic [3:0] prescaler;
  } div_cfg_t;

  typedef struct packed {
    logic fast_rc;
    logic primary;
    logic low_power;
    logic backup;
  } osc_ready_t;

  localparam src_t     SRC_RST = SRC_FAST_RC;
  localparam div_cfg_t DIV_RST = '{post2: 3'h1, post1: 3'h4, feedback: 8'h96, prescaler: 4'h1};

endpackage : clk_gen_pkg

// ==== verilog/pll_channel.sv ====
// One frequency multiplier channel: holds the applied divider set and run state.
// Assumes the analog multiplier reports lock synchronously to aclk.
`timescale 1ns/100ps
module pll_channel (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  input  wire logic                enable,
  input  wire logic                in_use,
  input  wire logic                lock_in,
  input  wire clk_gen_pkg::div_cfg_t cfg_req,
  output clk_gen_pkg::div_cfg_t    cfg_out,
  output logic                     run,
  output logic                     locked
);

  clk_gen_pkg::div_cfg_t cfg_r;
  clk_gen_pkg::div_cfg_t cfg_nxt;
  logic                  run_r;
  logic                  run_nxt;
  logic                  locked_r;
  logic                  locked_nxt;

  always_comb begin
    cfg_nxt    = cfg_r;
    run_nxt    = enable;
    locked_nxt = run_r & lock_in;
    if (ce) begin
      cfg_nxt.post1 = cfg_req.post1;
      cfg_nxt.post2 = cfg_req.post2;
      // Loop dividers move only while unused
      if (!in_use) begin
        cfg_nxt.prescaler = cfg_req.prescaler; // [R7]
        cfg_nxt.feedback  = cfg_req.feedback;  // [R7]
      end
    end else begin
      run_nxt    = run_r;
      locked_nxt = locked_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r    <= clk_gen_pkg::DIV_RST;
      run_r    <= 1'b0;
      locked_r <= 1'b0;
    end else begin
      cfg_r    <= cfg_nxt;
      run_r    <= run_nxt;
      locked_r <= locked_nxt;
    end
  end

  assign cfg_out = cfg_r;
  assign run     = run_r;
  assign locked  = locked_r;

endmodule : pll_channel

// ==== verilog/clk_gen.sv ====
// Clock generation control: source switch, main and auxiliary multipliers.
// Assumes oscillator ready and lock inputs are synchronous to aclk and
// that an external glitch-free mux follows sys_source.
// Operation
// [R1] Fast RC or primary may feed main multiplier
// [R2] Software keeps main input 8 to 64 MHz
// [R3] Phase detector 8 MHz up to VCO/16
// [R4] Software keeps main VCO 400-1600 MHz
// [R5] VCO is input times feedback over prescaler
// [R6] Output further divided by both post dividers
// [R7] Loop dividers change only off multiplier sources
// [R8] No direct switch between multiplier sources; code allows a direct 001 to 011 switch
// [R9] Code 001 plus request selects fast RC multiplied
// [R10] Auxiliary multiplier independent of system clock
// [R11] Software keeps auxiliary input 8 to 64 MHz
// [R12] Aux phase detector 8 MHz up to VCO/16
// [R13] Software keeps aux VCO 400-1600 MHz
// [R14] Aux VCO is input times feedback over prescaler
// [R15] Aux output further divided by post dividers
// [R16] Aux runs only when enabled and requested
// [R17] Instruction clock is system clock over two
// [R18] Code 011 selects primary multiplied, then lock
// [R19] Old source holds until new runs, then clears request
`timescale 1ns/100ps
module clk_gen (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     ce,
  input  wire logic [11:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [11:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire clk_gen_pkg::osc_ready_t  osc_ready,
  input  wire logic                     main_lock_in,
  input  wire logic                     aux_lock_in,
  input  wire logic                     aux_clock_request,
  output clk_gen_pkg::src_t             sys_source,
  output logic                          main_input_primary,
  output logic                          main_run,
  output clk_gen_pkg::div_cfg_t         main_cfg,
  output logic                          aux_run,
  output clk_gen_pkg::div_cfg_t         aux_cfg,
  output logic                          instr_clk_en
);

  typedef enum {SW_IDLE, SW_WAIT, SW_CHANGE} sw_state_t;

  // Register file and switch state
  clk_gen_pkg::src_t     new_source_select_r, new_source_select_nxt;
  clk_gen_pkg::src_t     cur_src_r, cur_src_nxt;
  clk_gen_pkg::src_t     tgt_src_r, tgt_src_nxt;
  logic                  switch_request_bit_r, switch_request_bit_nxt;
  sw_state_t             sw_state_r, sw_state_nxt;
  clk_gen_pkg::div_cfg_t main_div_r, main_div_nxt;
  clk_gen_pkg::div_cfg_t aux_div_r, aux_div_nxt;
  logic                  aux_multiplier_enable_r, aux_multiplier_enable_nxt;
  logic                  instr_phase_r, instr_phase_nxt;

  // Bus state
  logic                  aw_have_r, aw_have_nxt;
  logic [11:0]           awaddr_r, awaddr_nxt;
  logic                  w_have_r, w_have_nxt;
  logic [31:0]           wdata_r, wdata_nxt;
  logic [3:0]            wstrb_r, wstrb_nxt;
  logic                  bvalid_r, bvalid_nxt;
  logic [1:0]            bresp_r, bresp_nxt;
  logic                  rvalid_r, rvalid_nxt;
  logic [31:0]           rdata_r, rdata_nxt;
  logic [1:0]            rresp_r, rresp_nxt;

  logic                  main_locked;
  logic                  aux_locked;
  logic                  aux_running;
  logic                  do_write;
  logic [11:0]           wr_word;
  logic [11:0]           rd_word;
  logic [31:0]           wr_merged;
  logic                  sw_clear;
  logic                  tgt_ready;
  logic                  main_in_use;
  logic [31:0]           osc_img;
  logic [31:0]           main_img;
  logic [31:0]           aux_img;
  logic [31:0]           auxc_img;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : merge_bytes

  function automatic logic [31:0] div_image(input clk_gen_pkg::div_cfg_t d);
    logic [31:0] img;
    img = '0;
    img[clk_gen_pkg::PRE_LSB +: clk_gen_pkg::PRE_W]     = d.prescaler;
    img[clk_gen_pkg::FB_LSB +: clk_gen_pkg::FB_W]       = d.feedback;
    img[clk_gen_pkg::POST1_LSB +: clk_gen_pkg::POST_W]  = d.post1;
    img[clk_gen_pkg::POST2_LSB +: clk_gen_pkg::POST_W]  = d.post2;
    return img;
  endfunction : div_image

  function automatic clk_gen_pkg::div_cfg_t div_fields(input logic [31:0] v);
    clk_gen_pkg::div_cfg_t d;
    d.prescaler = v[clk_gen_pkg::PRE_LSB +: clk_gen_pkg::PRE_W];
    d.feedback  = v[clk_gen_pkg::FB_LSB +: clk_gen_pkg::FB_W];
    d.post1     = v[clk_gen_pkg::POST1_LSB +: clk_gen_pkg::POST_W];
    d.post2     = v[clk_gen_pkg::POST2_LSB +: clk_gen_pkg::POST_W];
    return d;
  endfunction : div_fields

  function automatic logic is_pll(input clk_gen_pkg::src_t s);
    return (s == clk_gen_pkg::SRC_FAST_RC_PLL) || (s == clk_gen_pkg::SRC_PRIMARY_PLL);
  endfunction : is_pll

  // Multiplied codes need only their input running
  function automatic logic src_ready(input clk_gen_pkg::src_t s,
                                     input clk_gen_pkg::osc_ready_t r);
    logic ok;
    case (s)
      clk_gen_pkg::SRC_FAST_RC,
      clk_gen_pkg::SRC_FAST_RC_PLL:  ok = r.fast_rc;
      clk_gen_pkg::SRC_PRIMARY,
      clk_gen_pkg::SRC_PRIMARY_PLL:  ok = r.primary;
      clk_gen_pkg::SRC_LOW_POWER_RC: ok = r.low_power;
      clk_gen_pkg::SRC_BACKUP_RC:    ok = r.backup;
      default:                       ok = 1'b0;
    endcase
    return ok;
  endfunction : src_ready

  function automatic logic src_valid(input logic [2:0] c);
    case (c)
      clk_gen_pkg::SRC_FAST_RC, clk_gen_pkg::SRC_FAST_RC_PLL,
      clk_gen_pkg::SRC_PRIMARY, clk_gen_pkg::SRC_PRIMARY_PLL,
      clk_gen_pkg::SRC_LOW_POWER_RC, clk_gen_pkg::SRC_BACKUP_RC: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : src_valid

  // Bus handshakes; ce low stalls every channel
  assign s_axi_awready = ce & ~aw_have_r & ~bvalid_r;
  assign s_axi_wready  = ce & ~w_have_r & ~bvalid_r;
  assign s_axi_arready = ce & ~rvalid_r;
  assign do_write      = ce & aw_have_r & w_have_r & ~bvalid_r;
  assign wr_word       = {awaddr_r[11:2], 2'h0};
  assign rd_word       = {s_axi_araddr[11:2], 2'h0};

  assign main_in_use = is_pll(cur_src_r);
  assign tgt_ready   = src_ready(tgt_src_r, osc_ready);

  always_comb begin
    osc_img = '0;
    osc_img[clk_gen_pkg::NEW_SRC_LSB +: clk_gen_pkg::SRC_W] = new_source_select_r;
    osc_img[clk_gen_pkg::CUR_SRC_LSB +: clk_gen_pkg::SRC_W] = cur_src_r;
    osc_img[clk_gen_pkg::SW_REQ_BIT]    = switch_request_bit_r;
    osc_img[clk_gen_pkg::MAIN_LOCK_BIT] = main_locked; // [R18]
    osc_img[clk_gen_pkg::AUX_LOCK_BIT]  = aux_locked;
    osc_img[clk_gen_pkg::SW_BUSY_BIT]   = (sw_state_r != SW_IDLE);
    main_img = div_image(main_div_r);
    aux_img  = div_image(aux_div_r);
    auxc_img = '0;
    auxc_img[clk_gen_pkg::AUX_EN_BIT]  = aux_multiplier_enable_r;
    auxc_img[clk_gen_pkg::AUX_RUN_BIT] = aux_running;
    auxc_img[clk_gen_pkg::AUX_REQ_BIT] = aux_clock_request;
    case (wr_word)
      clk_gen_pkg::OSC_CTRL_OFS: wr_merged = merge_bytes(osc_img, wdata_r, wstrb_r);
      clk_gen_pkg::MAIN_DIV_OFS: wr_merged = merge_bytes(main_img, wdata_r, wstrb_r);
      clk_gen_pkg::AUX_DIV_OFS:  wr_merged = merge_bytes(aux_img, wdata_r, wstrb_r);
      clk_gen_pkg::AUX_CTRL_OFS: wr_merged = merge_bytes(auxc_img, wdata_r, wstrb_r);
      default:                   wr_merged = '0;
    endcase
  end

  always_comb begin
    new_source_select_nxt     = new_source_select_r;
    cur_src_nxt               = cur_src_r;
    tgt_src_nxt               = tgt_src_r;
    sw_state_nxt              = sw_state_r;
    main_div_nxt              = main_div_r;
    aux_div_nxt               = aux_div_r;
    aux_multiplier_enable_nxt = aux_multiplier_enable_r;
    instr_phase_nxt           = instr_phase_r;
    aw_have_nxt               = aw_have_r;
    awaddr_nxt                = awaddr_r;
    w_have_nxt                = w_have_r;
    wdata_nxt                 = wdata_r;
    wstrb_nxt                 = wstrb_r;
    bvalid_nxt                = bvalid_r;
    bresp_nxt                 = bresp_r;
    rvalid_nxt                = rvalid_r;
    rdata_nxt                 = rdata_r;
    rresp_nxt                 = rresp_r;
    sw_clear                  = 1'b0;
    switch_request_bit_nxt    = switch_request_bit_r;
    if (ce) begin
      // Stands in for the selected source
      instr_phase_nxt = ~instr_phase_r; // [R17]
      // Old source drives until the target runs
      case (sw_state_r)
        SW_IDLE: begin
          if (switch_request_bit_r) begin
            tgt_src_nxt = new_source_select_r; // [R9] [R18]
            if (src_valid(new_source_select_r) && new_source_select_r != cur_src_r) begin
              sw_state_nxt = SW_WAIT;
            end else begin
              sw_clear = 1'b1;
            end
          end
        end
        SW_WAIT: begin
          if (tgt_ready) sw_state_nxt = SW_CHANGE; // [R19]
        end
        SW_CHANGE: begin
          cur_src_nxt  = tgt_src_r; // [R19]
          sw_clear     = 1'b1;      // [R19]
          sw_state_nxt = SW_IDLE;
        end
        default: sw_state_nxt = SW_IDLE;
      endcase
      if (sw_clear) switch_request_bit_nxt = 1'b0;
      // Write address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_nxt = 1'b1;
        awaddr_nxt  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_nxt = 1'b1;
        wdata_nxt  = s_axi_wdata;
        wstrb_nxt  = s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_nxt = 1'b0;
        w_have_nxt  = 1'b0;
        bvalid_nxt  = 1'b1;
        bresp_nxt   = clk_gen_pkg::RESP_OKAY;
        case (wr_word)
          clk_gen_pkg::OSC_CTRL_OFS: begin
            new_source_select_nxt =
              clk_gen_pkg::src_t'(wr_merged[clk_gen_pkg::NEW_SRC_LSB +: clk_gen_pkg::SRC_W]);
            // A set arriving with the hardware clear wins
            if (wr_merged[clk_gen_pkg::SW_REQ_BIT]) switch_request_bit_nxt = 1'b1; // [R9]
          end
          clk_gen_pkg::MAIN_DIV_OFS: main_div_nxt = div_fields(wr_merged);
          clk_gen_pkg::AUX_DIV_OFS:  aux_div_nxt  = div_fields(wr_merged);
          clk_gen_pkg::AUX_CTRL_OFS:
            aux_multiplier_enable_nxt = wr_merged[clk_gen_pkg::AUX_EN_BIT];
          default: bresp_nxt = clk_gen_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
      if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_nxt = 1'b1;
        rresp_nxt  = clk_gen_pkg::RESP_OKAY;
        case (rd_word)
          clk_gen_pkg::OSC_CTRL_OFS: rdata_nxt = osc_img;
          clk_gen_pkg::MAIN_DIV_OFS: rdata_nxt = main_img;
          clk_gen_pkg::AUX_DIV_OFS:  rdata_nxt = aux_img;
          clk_gen_pkg::AUX_CTRL_OFS: rdata_nxt = auxc_img;
          default: begin
            rdata_nxt = '0;
            rresp_nxt = clk_gen_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      new_source_select_r     <= clk_gen_pkg::SRC_RST;
      cur_src_r               <= clk_gen_pkg::SRC_RST;
      tgt_src_r               <= clk_gen_pkg::SRC_RST;
      switch_request_bit_r    <= 1'b0;
      sw_state_r              <= SW_IDLE;
      main_div_r              <= clk_gen_pkg::DIV_RST;
      aux_div_r               <= clk_gen_pkg::DIV_RST;
      aux_multiplier_enable_r <= 1'b0;
      instr_phase_r           <= 1'b0;
      aw_have_r               <= 1'b0;
      awaddr_r                <= '0;
      w_have_r                <= 1'b0;
      wdata_r                 <= '0;
      wstrb_r                 <= '0;
      bvalid_r                <= 1'b0;
      bresp_r                 <= clk_gen_pkg::RESP_OKAY;
      rvalid_r                <= 1'b0;
      rdata_r                 <= '0;
      rresp_r                 <= clk_gen_pkg::RESP_OKAY;
    end else begin
      new_source_select_r     <= new_source_select_nxt;
      cur_src_r               <= cur_src_nxt;
      tgt_src_r               <= tgt_src_nxt;
      switch_request_bit_r    <= switch_request_bit_nxt;
      sw_state_r              <= sw_state_nxt;
      main_div_r              <= main_div_nxt;
      aux_div_r               <= aux_div_nxt;
      aux_multiplier_enable_r <= aux_multiplier_enable_nxt;
      instr_phase_r           <= instr_phase_nxt;
      aw_have_r               <= aw_have_nxt;
      awaddr_r                <= awaddr_nxt;
      w_have_r                <= w_have_nxt;
      wdata_r                 <= wdata_nxt;
      wstrb_r                 <= wstrb_nxt;
      bvalid_r                <= bvalid_nxt;
      bresp_r                 <= bresp_nxt;
      rvalid_r                <= rvalid_nxt;
      rdata_r                 <= rdata_nxt;
      rresp_r                 <= rresp_nxt;
    end
  end

  // Runs for current or pending multiplied source
  pll_channel u_main (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .enable  (main_in_use | (sw_state_r != SW_IDLE && is_pll(tgt_src_r))), // [R1]
    .in_use  (main_in_use),                                                // [R7] [R8]
    .lock_in (main_lock_in),
    .cfg_req (main_div_r),   // [R5] [R6]
    .cfg_out (main_cfg),
    .run     (main_run),
    .locked  (main_locked)
  );

  // Auxiliary multiplier ignores the system source entirely
  pll_channel u_aux (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .enable  (aux_multiplier_enable_r & aux_clock_request), // [R10] [R16]
    .in_use  (aux_running),
    .lock_in (aux_lock_in),
    .cfg_req (aux_div_r),    // [R14] [R15]
    .cfg_out (aux_cfg),
    .run     (aux_running),
    .locked  (aux_locked)
  );

  // Follows the pending target so the loop settles first
  assign main_input_primary = (sw_state_r != SW_IDLE)
                              ? (tgt_src_r == clk_gen_pkg::SRC_PRIMARY_PLL)
                              : (cur_src_r == clk_gen_pkg::SRC_PRIMARY_PLL); // [R1]
  assign sys_source   = cur_src_r;
  assign aux_run      = aux_running;
  assign instr_clk_en = instr_phase_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule : clk_gen

// ==== sim/clk_gen_props.sv ====
// Port checker for clk_gen, attached by bind.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/100ps
module clk_gen_props (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    ce,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire clk_gen_pkg::osc_ready_t osc_ready,
  input wire logic                    aux_clock_request,
  input wire clk_gen_pkg::src_t       sys_source,
  input wire logic                    main_input_primary,
  input wire logic                    main_run,
  input wire clk_gen_pkg::div_cfg_t   main_cfg,
  input wire logic                    aux_run,
  input wire logic                    instr_clk_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire on_mult = (sys_source == clk_gen_pkg::SRC_FAST_RC_PLL) ||
                 (sys_source == clk_gen_pkg::SRC_PRIMARY_PLL);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence aux_idle;
    (!aux_clock_request && ce)[*3];
  endsequence
  AST_INSTR_TOGGLE: assert property (ce |=> instr_clk_en != $past(instr_clk_en))
    else $error("no instruction toggle");
  AST_AUX_GATE: assert property (aux_idle |=> !aux_run)
    else $error("aux runs unrequested");
  AST_MULT_RUNS: assert property (on_mult |-> main_run)
    else $error("multiplier off");
  AST_MULT_INPUT: assert property (on_mult |->
    main_input_primary == (sys_source == clk_gen_pkg::SRC_PRIMARY_PLL))
    else $error("wrong input");
  AST_LOOP_HOLD: assert property (on_mult && $past(on_mult) |->
    $stable(main_cfg.prescaler) && $stable(main_cfg.feedback))
    else $error("loop dividers moved");
  AST_PRIMARY_READY: assert property ($changed(sys_source) &&
    sys_source == clk_gen_pkg::SRC_PRIMARY_PLL |-> $past(osc_ready.primary, 2))
    else $error("primary not ready");
  AST_FAST_READY: assert property ($changed(sys_source) &&
    sys_source == clk_gen_pkg::SRC_FAST_RC_PLL |-> $past(osc_ready.fast_rc, 2))
    else $error("fast rc not ready");
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read unanswered");
  AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write unanswered");
  AST_CE_FREEZE: assert property (!ce |-> !s_axi_arready && !s_axi_awready && !s_axi_wready)
    else $error("ready with ce low");
endmodule : clk_gen_props

bind clk_gen clk_gen_props u_props (.*);

// ==== sim/tb_top.sv ====
// Self-checking bench for clk_gen over AXI4-Lite and its control ports.
// Assumes 100 MHz aclk and the register layout of clk_gen_pkg.
`timescale 1ns/100ps
module tb_top;
  localparam logic [11:0] OSC = 12'h000, MDIV = 12'h004, ADIV = 12'h008, ACTL = 12'h00c;
  localparam logic [1:0]  OK = clk_gen_pkg::RESP_OKAY, ER = clk_gen_pkg::RESP_SLVERR;
  logic        aclk, aresetn, ce, ie;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        main_lock_in, aux_lock_in, aux_clock_request, main_input_primary;
  logic        main_run, aux_run, instr_clk_en;
  clk_gen_pkg::osc_ready_t osc_ready;
  clk_gen_pkg::src_t       sys_source;
  clk_gen_pkg::div_cfg_t   main_cfg, aux_cfg;
  int          fail_count, checked;

  clk_gen dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .osc_ready, .main_lock_in, .aux_lock_in, .aux_clock_request, .sys_source,
    .main_input_primary, .main_run, .main_cfg, .aux_run, .aux_cfg, .instr_clk_en
  );

  always #5 aclk = ~aclk;

  task automatic report_and_stop();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic fail(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task automatic hang();
    fail("handshake timeout");
    report_and_stop();
  endtask : hang

  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) fail($sformatf("word %h expected %h", g, e));
  endtask : chk_w

  task automatic chk_b(input logic g, input logic e);
    checked++;
    if (g !== e) fail($sformatf("bit %b expected %b", g, e));
  endtask : chk_b

  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e) fail($sformatf("response %h expected %h", g, e));
  endtask : chk_r

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    logic aw, w, b = 1'b0;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b && n < 40) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) hang();
    chk_r(r, er);
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    int n = 0;
    logic ar, v = 1'b0;
    logic [1:0] r;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!v && n < 40) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!v) hang();
    chk_r(r, er);
    @(posedge aclk);
  endtask : axi_rd

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    axi_rd(a, OK, rd);
    chk_w(rd, e);
  endtask : rdc

  task automatic wait_switch();
    int n = 0;
    rd = 32'h100;
    while (rd[8] && n < 20) begin
      axi_rd(OSC, OK, rd);
      n++;
    end
    if (rd[8]) hang();
  endtask : wait_switch

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {main_lock_in, aux_lock_in, aux_clock_request} = '0;
    osc_ready = 4'h8;
    fail_count = 0;
    checked = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_w({29'h0, sys_source}, 32'h0);
    chk_w({14'h0, main_cfg}, 32'hc961);
    rdc(MDIV, 32'h0014_9601);
    rdc(ADIV, 32'h0014_9601);
    rdc(OSC, 32'h0);
    rdc(ACTL, 32'h0);
    axi_rd(12'h010, ER, rd);
    chk_w(rd, 32'h0);
    axi_wr(12'h010, 32'h1, ER);
    $display("test reset done");
    axi_wr(MDIV, 32'h0015_7d01, OK);
    axi_wr(ADIV, 32'h0012_6401, OK);
    rdc(MDIV, 32'h0015_7d01);
    chk_w({14'h0, main_cfg}, 32'hd7d1);
    chk_w({14'h0, aux_cfg}, 32'ha641);
    main_lock_in <= 1'b1;
    axi_wr(OSC, 32'h101, OK);
    wait_switch();
    chk_w({29'h0, sys_source}, 32'h1);
    chk_b(main_run, 1'b1);
    chk_b(main_input_primary, 1'b0);
    rdc(OSC, 32'h0000_0211);
    axi_wr(MDIV, 32'h0022_6401, OK);
    rdc(MDIV, 32'h0022_6401);
    chk_w({14'h0, main_cfg}, 32'h127d1);
    axi_wr(OSC, 32'h100, OK);
    wait_switch();
    chk_w({29'h0, sys_source}, 32'h0);
    chk_w({14'h0, main_cfg}, 32'h12641);
    $display("test fast rc multiplier done");
    axi_wr(OSC, 32'h103, OK);
    repeat (6) @(posedge aclk);
    chk_w({29'h0, sys_source}, 32'h0);
    axi_rd(OSC, OK, rd);
    chk_w(rd & 32'hffff_fdff, 32'h0000_0903);
    osc_ready <= 4'hc;
    wait_switch();
    chk_w({29'h0, sys_source}, 32'h3);
    chk_b(main_input_primary, 1'b1);
    axi_wr(OSC, 32'h104, OK);
    wait_switch();
    chk_w({29'h0, sys_source}, 32'h3);
    $display("test primary multiplier done");
    axi_wr(ACTL, 32'h1, OK);
    repeat (4) @(posedge aclk);
    chk_b(aux_run, 1'b0);
    rdc(ACTL, 32'h1);
    aux_clock_request <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_b(aux_run, 1'b1);
    rdc(ACTL, 32'h7);
    axi_wr(ADIV, 32'h0011_5001, OK);
    chk_w({14'h0, aux_cfg}, 32'h9641);
    aux_clock_request <= 1'b0;
    repeat (4) @(posedge aclk);
    chk_b(aux_run, 1'b0);
    $display("test aux multiplier done");
    @(negedge aclk);
    ie = instr_clk_en;
    @(negedge aclk);
    chk_b(instr_clk_en, ~ie);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (3) @(negedge aclk);
    chk_b(instr_clk_en, ie);
    chk_b(s_axi_arready, 1'b0);
    @(posedge aclk);
    ce <= 1'b1;
    @(posedge aclk);
    $display("test clock enable done");
    report_and_stop();
  end
endmodule : tb_top
